// ==== dmem_cfg_pkg.sv ====
// Constants, field layouts and carrier types for the data-memory control
// block. Assumes an AXI4-Lite master with 32-bit data and byte addresses.
// Function
// - Two data pointers share one address
// - Select 0 primary (default), 1 secondary
// - Bank select bits at status bits 4,3
// - Carry 7, half carry 6, overflow 2, parity 0
// - User flags bits 5,1 are plain storage
// - Large variant: 0000-03FF goes to auxiliary RAM
// - Small variant: 00-FF goes to auxiliary RAM
// - Disable bit set: auxiliary RAM never selected
// - Strobe free-runs at clock/3 or clock/6
// - Suppressed strobe only during move instructions
// - General user bit 3 is plain storage
// - Four banks of eight working registers
// - Register-indirect moves ignore pointer high byte unless the disable bit is set
package dmem_cfg_pkg;
   // Register word indices; the bus byte address is four times these
   localparam logic [7:0] IDX_AUX_CONTROL     = 8'h8E;
   localparam logic [7:0] IDX_AUX_CONTROL_TWO = 8'hA2;
   localparam logic [7:0] IDX_STATUS_WORD     = 8'hD0;
   localparam logic [7:0] IDX_POINTER_LOW     = 8'h82;
   localparam logic [7:0] IDX_POINTER_HIGH    = 8'h83;
   localparam int         ADDR_W              = 10;
   // Field positions
   localparam int BIT_CARRY        = 7;
   localparam int BIT_HALF_CARRY   = 6;
   localparam int BIT_USER_ZERO    = 5;
   localparam int BIT_BANK_HIGH    = 4;
   localparam int BIT_BANK_LOW     = 3;
   localparam int BIT_SIGNED_WRAP  = 2;
   localparam int BIT_USER_ONE     = 1;
   localparam int BIT_PARITY       = 0;
   localparam int BIT_AUX_DISABLE  = 1;
   localparam int BIT_STROBE_SUPP  = 0;
   localparam int BIT_GENERAL_USER = 3;
   localparam int BIT_POINTER_SEL  = 0;
   // Writable masks and reset values
   localparam logic [7:0] MASK_AUX_CONTROL  = 8'h03;
   localparam logic [7:0] MASK_AUX_TWO      = 8'h09;
   localparam logic [7:0] RST_AUX_CONTROL   = 8'h00;
   localparam logic [7:0] RST_AUX_TWO       = 8'h00;
   localparam logic [7:0] RST_STATUS        = 8'h00;
   // Auxiliary RAM top addresses for the two variants
   localparam logic [15:0] AUX_TOP_LARGE    = 16'h03FF;
   localparam logic [15:0] AUX_TOP_SMALL    = 16'h00FF;
   // Strobe periods in system clocks
   localparam logic [2:0] STROBE_DIV_6T     = 3'h3;
   localparam logic [2:0] STROBE_DIV_12T    = 3'h6;
   localparam logic [1:0] RESP_OKAY         = 2'h0;
   localparam logic [1:0] RESP_SLVERR       = 2'h2;

   // Core-side status flag update
   typedef struct packed {
      logic carry_flag;
      logic half_carry_flag;
      logic signed_wrap_flag;
      logic parity_flag;
   } alu_flags_t;

   // Core-side external-move request
   typedef struct packed {
      logic        valid;
      logic        register_indirect;
      logic        write;
      logic [15:0] pointer;
      logic [7:0]  low_byte;
   } move_req_t;

   // Routing decision for a move
   typedef struct packed {
      logic                 aux_select;
      logic                 offchip_start;
      logic [15:0]          address;
      logic [ADDR_W-1:0]    aux_address;
   } move_route_t;
endpackage : dmem_cfg_pkg

// ==== dmem_cfg_regs.sv ====
// Data-memory control registers: status word, auxiliary controls, dual
// data pointers, bank select, move routing and address-latch strobe.
// Assumes an AXI4-Lite master and a core on the same clock.
// Register indices are word indices: the byte address on the bus is four
// times the index, and the two lowest address bits are ignored.
// Core inputs arrive on i_clk and are used without synchronisers.
`timescale 1ns/100ps
module data_memory_config_regs #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   // AXI4-Lite write address and data
   input  wire logic                      i_awvalid,
   output logic                           o_awready,
   input  wire logic [9:0]                i_awaddr,
   input  wire logic                      i_wvalid,
   output logic                           o_wready,
   input  wire logic [31:0]               i_wdata,
   input  wire logic [3:0]                i_wstrb,
   // AXI4-Lite write response
   output logic                           o_bvalid,
   input  wire logic                      i_bready,
   output logic [1:0]                     o_bresp,
   // AXI4-Lite read
   input  wire logic                      i_arvalid,
   output logic                           o_arready,
   input  wire logic [9:0]                i_araddr,
   output logic                           o_rvalid,
   input  wire logic                      i_rready,
   output logic [31:0]                    o_rdata,
   output logic [1:0]                     o_rresp,
   // Core: flags, clock mode, instruction kind, moves
   input  wire logic                      i_flags_we,
   input  wire dmem_cfg_pkg::alu_flags_t  i_flags,
   input  wire logic                      i_mode_6t,
   input  wire logic                      i_move_instr_active,
   input  wire dmem_cfg_pkg::move_req_t   i_move,
   // Working-register bank
   output logic [1:0]                     o_bank_select,
   output logic [4:0]                     o_reg_base,
   // Selected pointer, move route and strobe
   output logic [15:0]                    o_pointer,
   output dmem_cfg_pkg::move_route_t      o_route,
   output logic                           o_strobe
);

   ////////////////////////////////////////////////////////////////////////
   // State
   // One packed struct holds every flip-flop of the block; the fields
   // run from the bus slots through the registers to the move route.
   typedef struct packed {
      logic                      aw_held;
      logic [7:0]                aw_addr;
      logic                      w_held;
      logic [7:0]                w_data;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
      logic [7:0]                status_word;
      logic [7:0]                aux_control;
      logic [7:0]                aux_control_two;
      logic [15:0]               primary_pointer;
      logic [15:0]               secondary_pointer;
      logic [2:0]                strobe_cnt;
      logic                      strobe;
      dmem_cfg_pkg::move_route_t route;
   } state_t;

   state_t st;       // Registered state
   state_t next_st;  // Next state

   // Combinational helpers between the state and the next state
   logic [7:0]  wr_addr;     // Effective write index
   logic [7:0]  wr_byte;     // Effective write byte
   logic        wr_fire;     // Write completes this cycle
   logic        wr_ok;       // Write address mapped
   logic [7:0]  rd_byte;     // Read mux result
   logic        rd_ok;       // Read address mapped
   logic [15:0] cur_ptr;     // Selected pointer
   logic [15:0] mv_addr;     // Move target address
   logic [15:0] aux_top;     // Auxiliary RAM top for variant
   logic [2:0]  strobe_div;  // Strobe period in clocks

   ////////////////////////////////////////////////////////////////////////
   // Bus handshakes: one slot per channel, held until the pair completes.
   // A pending response blocks both write channels, so only one write is
   // ever under way; arready falls while a read answer waits, which
   // limits reads to one at a time as well.
   assign o_awready = !st.aw_held && !st.bvalid;
   assign o_wready  = !st.w_held && !st.bvalid;
   assign o_arready = !st.rvalid;
   // Response and read data come straight from their flip-flops
   assign o_bvalid  = st.bvalid;
   assign o_bresp   = st.bresp;
   assign o_rvalid  = st.rvalid;
   assign o_rdata   = st.rdata;
   assign o_rresp   = st.rresp;

   // Current pointer chosen by the select bit
   // One mux feeds the output and the read path, so a select change
   // is seen by the very next access.
   assign cur_ptr = st.aux_control_two[dmem_cfg_pkg::BIT_POINTER_SEL]
                  ? st.secondary_pointer : st.primary_pointer;

   // Variant-dependent auxiliary RAM top
   // Fixed at build time; the small variant decodes a lower top
   assign aux_top = LARGE_VARIANT ? dmem_cfg_pkg::AUX_TOP_LARGE
                                  : dmem_cfg_pkg::AUX_TOP_SMALL;

   // Register-indirect moves drop the high byte while aux RAM is on
   // With auxiliary RAM off the full pointer goes out unchanged, so
   // external paging through the high byte still works.
   assign mv_addr = (i_move.register_indirect
                    && !st.aux_control[dmem_cfg_pkg::BIT_AUX_DISABLE])
                  ? {8'h00, i_move.low_byte} : i_move.pointer;

   // Strobe period by clock mode
   // The mode may change at any time; the counter wraps within a period
   assign strobe_div = i_mode_6t ? dmem_cfg_pkg::STROBE_DIV_6T
                                 : dmem_cfg_pkg::STROBE_DIV_12T;

   ////////////////////////////////////////////////////////////////////////
   // Outputs from state
   // Bank base is the bank number times eight working registers
   assign o_bank_select = {st.status_word[dmem_cfg_pkg::BIT_BANK_HIGH],
                           st.status_word[dmem_cfg_pkg::BIT_BANK_LOW]};
   assign o_reg_base = {o_bank_select, 3'h0};
   assign o_pointer  = cur_ptr;
   assign o_route    = st.route;
   assign o_strobe   = st.strobe;

   ////////////////////////////////////////////////////////////////////////
   // Write decode helpers; the index is the word address, so the two
   // lowest byte-address bits are ignored
   assign wr_addr = st.aw_held ? st.aw_addr : i_awaddr[9:2];
   assign wr_byte = st.w_held ? st.w_data : i_wdata[7:0];
   // Fires on the edge where the second of the pair arrives
   assign wr_fire = (st.aw_held || (i_awvalid && o_awready))
                 && (st.w_held || (i_wvalid && o_wready));
   // Unmapped indices still complete, with an error response
   always_comb begin
      // Mapped write addresses
      case (wr_addr)
         dmem_cfg_pkg::IDX_AUX_CONTROL,
         dmem_cfg_pkg::IDX_AUX_CONTROL_TWO,
         dmem_cfg_pkg::IDX_STATUS_WORD,
         dmem_cfg_pkg::IDX_POINTER_LOW,
         dmem_cfg_pkg::IDX_POINTER_HIGH: wr_ok = 1'b1;
         default:                        wr_ok = 1'b0;
      endcase
   end

   // Read mux; pointer locations reach whichever pointer is selected
   // Decoded straight from the address bus; the result is captured into
   // the read data register on acceptance only.
   always_comb begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      case (i_araddr[9:2])
         dmem_cfg_pkg::IDX_AUX_CONTROL:     rd_byte = st.aux_control;
         dmem_cfg_pkg::IDX_AUX_CONTROL_TWO: rd_byte = st.aux_control_two;
         dmem_cfg_pkg::IDX_STATUS_WORD:     rd_byte = st.status_word;
         dmem_cfg_pkg::IDX_POINTER_LOW:     rd_byte = cur_ptr[7:0];
         dmem_cfg_pkg::IDX_POINTER_HIGH:    rd_byte = cur_ptr[15:8];
         default:                           rd_ok   = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      // Defaults: every field holds unless a branch below moves it
      next_st = st;
      // Capture write address and data in either order; a channel that
      // arrives alone is parked until its partner comes
      if (i_awvalid && o_awready && !wr_fire) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = i_awaddr[9:2];
      end
      if (i_wvalid && o_wready && !wr_fire) begin
         next_st.w_held = 1'b1;
         next_st.w_data = i_wdata[7:0];
      end
      // Response leaves at the edge where the master is ready
      if (st.bvalid && i_bready) begin
         next_st.bvalid = 1'b0;
      end
      // Core flag updates; user flags and bank bits untouched
      // The core may load flags on any cycle, even during a bus write
      if (i_flags_we) begin
         next_st.status_word[dmem_cfg_pkg::BIT_CARRY] =
            i_flags.carry_flag;
         next_st.status_word[dmem_cfg_pkg::BIT_HALF_CARRY] =
            i_flags.half_carry_flag;
         next_st.status_word[dmem_cfg_pkg::BIT_SIGNED_WRAP] =
            i_flags.signed_wrap_flag;
         next_st.status_word[dmem_cfg_pkg::BIT_PARITY] =
            i_flags.parity_flag;
      end
      // Completed write; software wins over a same-cycle core update
      if (wr_fire) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_ok ? dmem_cfg_pkg::RESP_OKAY
                                 : dmem_cfg_pkg::RESP_SLVERR;
         // Only byte lane zero carries register data
         if (!i_wstrb[0]) begin
            // No low lane: nothing stored
         end else begin
            case (wr_addr)
               dmem_cfg_pkg::IDX_AUX_CONTROL:
                  next_st.aux_control =
                     wr_byte & dmem_cfg_pkg::MASK_AUX_CONTROL;
               // Only the select bit and the user bit are kept
               dmem_cfg_pkg::IDX_AUX_CONTROL_TWO:
                  next_st.aux_control_two =
                     wr_byte & dmem_cfg_pkg::MASK_AUX_TWO;
               // Software may overwrite every status bit, flags too
               dmem_cfg_pkg::IDX_STATUS_WORD:
                  next_st.status_word = wr_byte;
               // Pointer writes reach only the selected pointer
               dmem_cfg_pkg::IDX_POINTER_LOW: begin
                  if (st.aux_control_two[dmem_cfg_pkg::BIT_POINTER_SEL])
                     next_st.secondary_pointer[7:0] = wr_byte;
                  else
                     next_st.primary_pointer[7:0] = wr_byte;
               end
               // High byte goes to the same selected pointer
               dmem_cfg_pkg::IDX_POINTER_HIGH: begin
                  if (st.aux_control_two[dmem_cfg_pkg::BIT_POINTER_SEL])
                     next_st.secondary_pointer[15:8] = wr_byte;
                  else
                     next_st.primary_pointer[15:8] = wr_byte;
               end
               default: begin
                  // Unmapped: answered with an error only
               end
            endcase
         end
      end
      // Read channel
      // A new request is not accepted while an answer waits
      if (st.rvalid && i_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (i_arvalid && o_arready) begin
         next_st.rvalid = 1'b1;
         // Upper data bits always read as zero
         next_st.rdata  = {24'h000000, rd_byte};
         next_st.rresp  = rd_ok ? dmem_cfg_pkg::RESP_OKAY
                                : dmem_cfg_pkg::RESP_SLVERR;
      end
      // Move routing, registered one cycle after the request
      // Registered so the route stands for a full cycle; the cost is one
      // cycle of latency on every move
      next_st.route.address     = mv_addr;
      next_st.route.aux_address = mv_addr[dmem_cfg_pkg::ADDR_W-1:0];
      next_st.route.aux_select  = i_move.valid
         && !st.aux_control[dmem_cfg_pkg::BIT_AUX_DISABLE]
         && (mv_addr <= aux_top);
      // Aux hits stay internal; everything else goes off-chip
      // A move with the disable bit set always goes off-chip
      next_st.route.offchip_start = i_move.valid
         && !next_st.route.aux_select;
      // Strobe: free-running divider, or only during move instructions
      // The divider runs in both modes, so a suppressed strobe keeps its
      // phase when a move instruction begins
      if (st.strobe_cnt >= strobe_div - 3'h1) begin
         next_st.strobe_cnt = 3'h0;
      end else begin
         next_st.strobe_cnt = st.strobe_cnt + 3'h1;
      end
      if (!st.aux_control[dmem_cfg_pkg::BIT_STROBE_SUPP]) begin
         next_st.strobe = (st.strobe_cnt == 3'h0);
      end else begin
         next_st.strobe = i_move_instr_active
                       && (st.strobe_cnt == 3'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   // The reset branch uses constants only, so the register clears
   // cleanly whatever the core inputs are doing; fields with named
   // reset values are set after the blanket clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st                 <= '0;
         st.status_word     <= dmem_cfg_pkg::RST_STATUS;
         st.aux_control     <= dmem_cfg_pkg::RST_AUX_CONTROL;
         st.aux_control_two <= dmem_cfg_pkg::RST_AUX_TWO;
      end else begin
         st <= next_st;
      end
   end

endmodule : data_memory_config_regs

// ==== dmem_cfg_regs_props.sv ====
// Checker for the data-memory control block, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module dmem_cfg_regs_props #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock, reset and register bus
   input wire logic i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready,
   input wire logic i_arvalid, i_rready, o_awready, o_wready,
   input wire logic o_bvalid, o_arready, o_rvalid,
   input wire logic [9:0] i_awaddr, i_araddr,
   input wire logic [31:0] i_wdata, o_rdata,
   input wire logic [3:0] i_wstrb,
   input wire logic [1:0] o_bresp, o_rresp,
   // Core side and outputs
   input wire logic i_flags_we, i_mode_6t, i_move_instr_active, o_strobe,
   input wire dmem_cfg_pkg::alu_flags_t i_flags,
   input wire dmem_cfg_pkg::move_req_t i_move,
   input wire logic [1:0] o_bank_select,
   input wire logic [4:0] o_reg_base,
   input wire logic [15:0] o_pointer,
   input wire dmem_cfg_pkg::move_route_t o_route
);
   // Top of on-chip auxiliary range for this variant
   localparam logic [15:0] TOP = LARGE_VARIANT ?
      dmem_cfg_pkg::AUX_TOP_LARGE : dmem_cfg_pkg::AUX_TOP_SMALL;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////
   a_bank_base: assert property (o_reg_base == {o_bank_select, 3'h0})
      else $error("register base does not follow bank select");
   a_route_excl: assert property (!(o_route.aux_select && o_route.offchip_start))
      else $error("auxiliary access also started an off-chip cycle");
   a_above_top: assert property (i_move.valid && !i_move.register_indirect
      && i_move.pointer > TOP |=> !o_route.aux_select)
      else $error("address above auxiliary top routed on chip");
   a_move_served: assert property (i_move.valid
      |=> o_route.aux_select || o_route.offchip_start)
      else $error("valid move neither on chip nor off chip");
   a_move_idle: assert property (!i_move.valid
      |=> !o_route.aux_select && !o_route.offchip_start)
      else $error("route active without a move");
   a_indirect_high: assert property (i_move.valid && i_move.register_indirect
      |=> (o_route.aux_select |-> o_route.address[15:8] == 8'h00))
      else $error("register-indirect move kept the high byte");
   a_strobe_gap: assert property (o_strobe |=> !o_strobe ##1 !o_strobe)
      else $error("strobe pulses closer than three clocks");
   a_resp_hold: assert property (o_bvalid && !i_bready
      |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before acceptance");
   a_read_answer: assert property (i_arvalid && o_arready
      |=> o_rvalid && o_rdata[31:8] == 24'h0)
      else $error("read answer late or upper bits set");
   a_bank_write: assert property (i_awvalid && o_awready && i_wvalid
      && o_wready && i_wstrb[0]
      && i_awaddr[9:2] == dmem_cfg_pkg::IDX_STATUS_WORD
      |=> o_bank_select == $past(i_wdata[4:3]))
      else $error("bank select does not follow status write");
endmodule : dmem_cfg_regs_props

// ==== tb.sv ====
// Self-checking bench for the data-memory control block.
// Assumes the package and block compiled first; drives every port itself.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
   logic i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_strobe;
   logic i_flags_we, i_mode_6t, i_move_instr_active;
   logic [9:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0] i_wstrb;
   logic [1:0] o_bresp, o_rresp, o_bank_select;
   logic [4:0] o_reg_base;
   logic [15:0] o_pointer;
   dmem_cfg_pkg::alu_flags_t i_flags;
   dmem_cfg_pkg::move_req_t i_move;
   dmem_cfg_pkg::move_route_t o_route;
   dmem_cfg_pkg::move_route_t o_route_small;
   int miscompares = 0;
   int num_checks = 0;
   logic [7:0] d;
   logic [1:0] r;
   int c;

   data_memory_config_regs #(.LARGE_VARIANT(1'b1)) i_dut (.*);
   // Small-variant copy: same inputs, only its move route is watched
   data_memory_config_regs #(.LARGE_VARIANT(1'b0)) i_dut_small (
      .*,
      .o_awready     (),
      .o_wready      (),
      .o_bvalid      (),
      .o_bresp       (),
      .o_arready     (),
      .o_rvalid      (),
      .o_rdata       (),
      .o_rresp       (),
      .o_bank_select (),
      .o_reg_base    (),
      .o_pointer     (),
      .o_route       (o_route_small),
      .o_strobe      ()
   );

   ////////////////////////////////////////////////////////////////////////
   // Free-running clock, 10 ns period
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Verdict and end of run
   task automatic finish_test;
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // Bus write; handshakes judged at the falling edge, released on the rise
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      logic ah, wh, bh;
      n = 0;
      bh = 1'b0;
      @(posedge i_clk);
      i_awvalid <= 1'b1;
      i_awaddr <= {a, 2'b00};
      i_wvalid <= 1'b1;
      i_wdata <= {24'h0, v};
      i_bready <= 1'b1;
      while (!bh && n < 50) begin
         @(negedge i_clk);
         ah = i_awvalid && o_awready;
         wh = i_wvalid && o_wready;
         bh = o_bvalid;
         r = o_bresp;
         @(posedge i_clk);
         if (ah) i_awvalid <= 1'b0;
         if (wh) i_wvalid <= 1'b0;
         n++;
      end
      i_bready <= 1'b0;
      if (!bh) begin
         miscompares++;
         finish_test();
      end
   endtask : wr

   // Bus read of the low byte
   task automatic rd(input logic [7:0] a);
      int n;
      logic ah, rh;
      n = 0;
      rh = 1'b0;
      @(posedge i_clk);
      i_arvalid <= 1'b1;
      i_araddr <= {a, 2'b00};
      i_rready <= 1'b1;
      while (!rh && n < 50) begin
         @(negedge i_clk);
         ah = i_arvalid && o_arready;
         rh = o_rvalid;
         d = o_rdata[7:0];
         r = o_rresp;
         @(posedge i_clk);
         if (ah) i_arvalid <= 1'b0;
         n++;
      end
      i_rready <= 1'b0;
      if (!rh) begin
         miscompares++;
         finish_test();
      end
   endtask : rd

   // One move request, route judged one clock later
   task automatic mv(input logic [15:0] p, input logic ind, input logic ea,
                     input logic [15:0] ead);
      @(posedge i_clk);
      i_move <= '{1'b1, ind, 1'b0, p, p[7:0]};
      @(posedge i_clk);
      i_move.valid <= 1'b0;
      #1;
      `CHK(o_route.aux_select, ea)
      `CHK(o_route.offchip_start, !ea)
      `CHK(o_route.address, ead)
      `CHK(o_route.aux_address, ead[9:0])
      `CHK(o_route_small.aux_select, ea && (ead <= 16'h00FF))
   endtask : mv

   // Strobe pulses counted over 30 clocks after settling
   task automatic cnt(input logic m6, input logic act);
      @(posedge i_clk);
      i_mode_6t <= m6;
      i_move_instr_active <= act;
      repeat (12) @(posedge i_clk);
      c = 0;
      repeat (30) begin
         @(posedge i_clk);
         #1;
         c += (o_strobe === 1'b1);
      end
   endtask : cnt

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
      {i_flags_we, i_mode_6t, i_move_instr_active} = '0;
      {i_awaddr, i_araddr, i_wdata} = '0;
      i_wstrb = 4'hF;
      i_flags = '0;
      i_move = '0;
      i_rst_n = 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // Reset state: primary pointer selected, pointer zero
      rd(dmem_cfg_pkg::IDX_AUX_CONTROL_TWO);
      `CHK(d, 8'h00)
      `CHK(r, dmem_cfg_pkg::RESP_OKAY)
      `CHK(o_pointer, 16'h0000)
      // Every bank, with user flags as plain storage
      for (int b = 0; b < 4; b++) begin
         wr(dmem_cfg_pkg::IDX_STATUS_WORD, 8'(b << 3) | 8'h22);
         rd(dmem_cfg_pkg::IDX_STATUS_WORD);
         `CHK(d, 8'(b << 3) | 8'h22)
         `CHK(o_bank_select, 2'(b))
         `CHK(o_reg_base, 5'(b * 8))
      end
      // Core flag update lands on bits 7, 6, 2 and 0
      wr(dmem_cfg_pkg::IDX_STATUS_WORD, 8'h00);
      @(posedge i_clk);
      i_flags <= '{1'b1, 1'b1, 1'b1, 1'b1};
      i_flags_we <= 1'b1;
      @(posedge i_clk);
      i_flags_we <= 1'b0;
      rd(dmem_cfg_pkg::IDX_STATUS_WORD);
      `CHK(d, 8'hC5)
      // A write without byte lane zero stores nothing
      i_wstrb <= 4'hE;
      wr(dmem_cfg_pkg::IDX_STATUS_WORD, 8'hFF);
      i_wstrb <= 4'hF;
      rd(dmem_cfg_pkg::IDX_STATUS_WORD);
      `CHK(d, 8'hC5)
      // Writable masks, unmapped slot refused
      wr(dmem_cfg_pkg::IDX_AUX_CONTROL_TWO, 8'hFF);
      rd(dmem_cfg_pkg::IDX_AUX_CONTROL_TWO);
      `CHK(d, 8'h09)
      wr(8'h40, 8'h5A);
      `CHK(r, dmem_cfg_pkg::RESP_SLVERR)
      // Two pointers behind one address
      wr(dmem_cfg_pkg::IDX_POINTER_LOW, 8'h56);
      wr(dmem_cfg_pkg::IDX_POINTER_HIGH, 8'h78);
      `CHK(o_pointer, 16'h7856)
      wr(dmem_cfg_pkg::IDX_AUX_CONTROL_TWO, 8'h00);
      `CHK(o_pointer, 16'h0000)
      wr(dmem_cfg_pkg::IDX_POINTER_LOW, 8'h12);
      wr(dmem_cfg_pkg::IDX_AUX_CONTROL_TWO, 8'h01);
      `CHK(r, dmem_cfg_pkg::RESP_OKAY)
      `CHK(o_pointer, 16'h7856)
      rd(dmem_cfg_pkg::IDX_POINTER_HIGH);
      `CHK(d, 8'h78)
      rd(8'h40);
      `CHK(r, dmem_cfg_pkg::RESP_SLVERR)
      // Move routing at the boundary and with the disable bit
      wr(dmem_cfg_pkg::IDX_AUX_CONTROL, 8'h00);
      mv(16'h03FF, 1'b0, 1'b1, 16'h03FF);
      mv(16'h0400, 1'b0, 1'b0, 16'h0400);
      mv(16'h0100, 1'b0, 1'b1, 16'h0100);
      mv(16'hFFAB, 1'b1, 1'b1, 16'h00AB);
      wr(dmem_cfg_pkg::IDX_AUX_CONTROL, 8'hFF);
      rd(dmem_cfg_pkg::IDX_AUX_CONTROL);
      `CHK(d, 8'h03)
      mv(16'h0000, 1'b0, 1'b0, 16'h0000);
      // Strobe rates, suppressed and enabled by move instructions
      cnt(1'b0, 1'b0);
      `CHK(c, 0)
      cnt(1'b0, 1'b1);
      `CHK(c, 5)
      wr(dmem_cfg_pkg::IDX_AUX_CONTROL, 8'h00);
      cnt(1'b1, 1'b0);
      `CHK(c, 10)
      cnt(1'b0, 1'b0);
      `CHK(c, 5)
      finish_test();
   end
endmodule : tb

bind data_memory_config_regs dmem_cfg_regs_props
   #(.LARGE_VARIANT(LARGE_VARIANT)) i_props (.*);
